// [design/rsw_pkg.sv]
// constants for the reset supervisor with watchdog
// assumes a single 40 MHz system clock and no software-visible registers
// What this block does
// - power-fail active holds both reset outputs active.
// - after power-fail clears, resets stay active at least 250 ms.
// - pushbutton counts as pressed only when low.
// - pushbutton is debounced; a press yields resets of at least 250 ms.
// - pushbutton 250 ms stretch starts when the button returns high.
// - resets go active when kick is not seen within the period.
// - period select: low 150 ms, float 600 ms, high 1.2 s.
// - watchdog count starts from full period when resets go inactive.
// - a falling kick edge before expiry restarts the full period.
// - watchdog expiry drives resets active at least 250 ms.
// - two resets always together: active high, and active-low open drain.
// - watchdog cannot be disabled.
// - resets active within 20 ms of the button becoming stably low.
package rsw_pkg;
    // =====================================================================
    // timing
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned STRETCH_MS    = 250;
    localparam int unsigned DEBOUNCE_MS   = 10;
    localparam int unsigned WD_SHORT_MS   = 150;
    localparam int unsigned WD_MID_MS     = 600;
    localparam int unsigned WD_LONG_MS    = 1200;
    localparam int unsigned STRETCH_CYC   = STRETCH_MS * (CLK_HZ / 1000);
    localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * (CLK_HZ / 1000);
    localparam int unsigned WD_SHORT_CYC  = WD_SHORT_MS * (CLK_HZ / 1000);
    localparam int unsigned WD_MID_CYC    = WD_MID_MS * (CLK_HZ / 1000);
    localparam int unsigned WD_LONG_CYC   = WD_LONG_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W         = 26;

    // =====================================================================
    // period select encoding of the three-level input
    typedef enum logic [1:0] {
        RSW_SEL_GND   = 2'h0,
        RSW_SEL_FLOAT = 2'h1,
        RSW_SEL_VCC   = 2'h2
    } rsw_sel_t;

    // reset sequencer states, gray along hold -> stretch -> run
    typedef enum logic [1:0] {
        RSW_HOLD    = 2'h0,
        RSW_STRETCH = 2'h1,
        RSW_RUN     = 2'h3
    } rsw_state_t;
endpackage : rsw_pkg

// [design/rsw_supervisor.sv]
// reset supervisor: power-fail, debounced pushbutton and watchdog reset causes
// assumes power_fail is synchronous to clk_sys; button and kick are asynchronous
`timescale 1ns/1ps
module rsw_supervisor
    import rsw_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES  = STRETCH_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
    parameter int unsigned WD_SHORT_CYCLES = WD_SHORT_CYC,
    parameter int unsigned WD_MID_CYCLES   = WD_MID_CYC,
    parameter int unsigned WD_LONG_CYCLES  = WD_LONG_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       power_fail,
    input  wire logic       pushbutton_reset_n,
    input  wire logic       kick_input_n,
    input  wire logic [1:0] watchdog_period_select,
    output logic            reset_out,
    output logic            reset_out_n_o,
    output logic            reset_out_n_oe
);

    // =====================================================================
    // helpers
    function automatic logic [CNT_W-1:0] wd_period(input logic [1:0] sel);
        case (sel)
            RSW_SEL_GND:   wd_period = CNT_W'(WD_SHORT_CYCLES);
            RSW_SEL_FLOAT: wd_period = CNT_W'(WD_MID_CYCLES);
            RSW_SEL_VCC:   wd_period = CNT_W'(WD_LONG_CYCLES);
            default:       wd_period = CNT_W'(WD_MID_CYCLES);
        endcase
    endfunction : wd_period

    // =====================================================================
    // input synchronisers
    logic [1:0] pb_sync;
    logic [1:0] kick_sync;
    logic       kick_prev;
    logic [1:0] next_pb_sync;
    logic [1:0] next_kick_sync;
    logic       next_kick_prev;
    logic       kick_fall;

    always_comb begin
        next_pb_sync   = {pb_sync[0], pushbutton_reset_n};
        next_kick_sync = {kick_sync[0], kick_input_n};
        next_kick_prev = kick_sync[1];
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pb_sync   <= 2'h3;
            kick_sync <= 2'h3;
            kick_prev <= 1'b1;
        end else begin
            pb_sync   <= next_pb_sync;
            kick_sync <= next_kick_sync;
            kick_prev <= next_kick_prev;
        end
    end

    assign kick_fall = kick_prev & ~kick_sync[1];

    // =====================================================================
    // pushbutton debounce: level must hold for the debounce time to count
    logic             pb_pressed;
    logic [CNT_W-1:0] db_cnt;
    logic             next_pb_pressed;
    logic [CNT_W-1:0] next_db_cnt;

    always_comb begin
        next_pb_pressed = pb_pressed;
        next_db_cnt     = '0;
        // low means pressed, high released
        if ((~pb_sync[1]) != pb_pressed) begin
            if (db_cnt >= CNT_W'(DEBOUNCE_CYCLES - 1)) begin
                next_pb_pressed = ~pb_sync[1];
            end else begin
                next_db_cnt = db_cnt + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pb_pressed <= 1'b0;
            db_cnt     <= '0;
        end else begin
            pb_pressed <= next_pb_pressed;
            db_cnt     <= next_db_cnt;
        end
    end

    // =====================================================================
    // reset sequencer and watchdog
    // one shared stretch counter: any cause reloads it, so the release is
    // always a full stretch after the last cause clears
    rsw_state_t       state;
    logic [CNT_W-1:0] cnt;
    logic             rst_act;
    rsw_state_t       next_state;
    logic [CNT_W-1:0] next_cnt;
    logic             next_rst_act;
    logic             hold_cause;

    // pushbutton holds until released, so its stretch begins on release
    assign hold_cause = power_fail | pb_pressed;

    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_rst_act = 1'b1;
        case (state)
            RSW_HOLD: begin
                next_cnt = CNT_W'(STRETCH_CYCLES - 1);
                if (!hold_cause) begin
                    next_state = RSW_STRETCH;
                end
            end
            RSW_STRETCH: begin
                if (hold_cause) begin
                    next_state = RSW_HOLD;
                end else if (cnt == '0) begin
                    next_state   = RSW_RUN;
                    next_cnt     = wd_period(watchdog_period_select) - CNT_W'(1);
                    next_rst_act = 1'b0;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            RSW_RUN: begin
                next_rst_act = 1'b0;
                // watchdog always runs here; there is no disable path
                if (hold_cause) begin
                    next_state   = RSW_HOLD;
                    next_rst_act = 1'b1;
                end else if (kick_fall) begin
                    next_cnt = wd_period(watchdog_period_select) - CNT_W'(1);
                end else if (cnt == '0) begin
                    next_state   = RSW_STRETCH;
                    next_cnt     = CNT_W'(STRETCH_CYCLES - 1);
                    next_rst_act = 1'b1;
                end else begin
                    next_cnt = cnt - CNT_W'(1);
                end
            end
            default: begin
                next_state = RSW_HOLD;
                next_cnt   = CNT_W'(STRETCH_CYCLES - 1);
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state   <= RSW_HOLD;
            cnt     <= '0;
            rst_act <= 1'b1;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            rst_act <= next_rst_act;
        end
    end

    // =====================================================================
    // outputs: both resets from registers so they move on the same edge
    logic next_reset_out;
    logic next_reset_out_n_oe;

    always_comb begin
        next_reset_out      = next_rst_act;
        next_reset_out_n_oe = next_rst_act;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reset_out      <= 1'b1;
            reset_out_n_o  <= 1'b0;
            reset_out_n_oe <= 1'b1;
        end else begin
            reset_out      <= next_reset_out;
            reset_out_n_o  <= 1'b0;
            reset_out_n_oe <= next_reset_out_n_oe;
        end
    end

endmodule : rsw_supervisor

// [dv/rsw_checker.sv]
// assertions on the reset supervisor ports
// assumes the select is held steady while kicks are withheld
`timescale 1ns/1ps
module rsw_checker
    import rsw_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES  = STRETCH_CYC,
    parameter int unsigned WD_SHORT_CYCLES = WD_SHORT_CYC,
    parameter int unsigned WD_MID_CYCLES   = WD_MID_CYC,
    parameter int unsigned WD_LONG_CYCLES  = WD_LONG_CYC
) (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       power_fail,
    input wire logic       pushbutton_reset_n,
    input wire logic       kick_input_n,
    input wire logic [1:0] watchdog_period_select,
    input wire logic       reset_out,
    input wire logic       reset_out_n_o,
    input wire logic       reset_out_n_oe
);
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ====================
    // helpers: calm counts reset with no cause, wd counts run since a raw kick
    logic [31:0] calm, wd, pb_hi, lim;
    logic        kick_q;
    assign lim = (watchdog_period_select == 2'h0) ? WD_SHORT_CYCLES :
                 (watchdog_period_select == 2'h2) ? WD_LONG_CYCLES : WD_MID_CYCLES;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            calm   <= '0;
            wd     <= '0;
            pb_hi  <= '0;
            kick_q <= 1'b1;
        end else begin
            calm   <= (reset_out && !power_fail && pushbutton_reset_n) ? calm + 1 : '0;
            wd     <= (reset_out || (kick_q && !kick_input_n)) ? '0 : wd + 1;
            pb_hi  <= pushbutton_reset_n ? pb_hi + 1 : '0;
            kick_q <= kick_input_n;
        end
    end
    // ====================
    // assertions; margins allow for the input synchronisers
    a_outputs_paired: assert property (
        reset_out_n_oe == reset_out && reset_out_n_o == 1'b0) else $error("pair split");
    a_fail_holds: assert property (
        power_fail |-> ##2 reset_out) else $error("fail not held");
    a_fail_no_release: assert property (
        $past(power_fail) |-> !$fell(reset_out)) else $error("released in fail");
    a_press_asserts: assert property (
        (!pushbutton_reset_n)[*8] |-> ##[0:4] reset_out) else $error("press missed");
    a_stretch_min: assert property (
        $fell(reset_out) |-> calm >= STRETCH_CYCLES) else $error("stretch short");
    a_stretch_ends: assert property (
        calm == STRETCH_CYCLES + 16 |-> !reset_out) else $error("stretch long");
    a_wd_expires: assert property (
        !reset_out |-> wd <= lim + 8) else $error("no expiry");
    a_wd_not_early: assert property (
        $rose(reset_out) && pb_hi > 20 && !$past(power_fail) && !$past(power_fail, 2)
        |-> wd + 4 >= lim) else $error("early expiry");
    c_wd: cover property ($rose(reset_out) && pb_hi > 20 && !$past(power_fail, 2));
    c_press: cover property ((!pushbutton_reset_n)[*8]);
    c_fail: cover property ($rose(power_fail) && !reset_out);
endmodule : rsw_checker

bind rsw_supervisor rsw_checker #(.STRETCH_CYCLES(STRETCH_CYCLES),
    .WD_SHORT_CYCLES(WD_SHORT_CYCLES), .WD_MID_CYCLES(WD_MID_CYCLES),
    .WD_LONG_CYCLES(WD_LONG_CYCLES)) u_chk (.*);

// [dv/rsw_cpu_model.sv]
// processor stand-in: watches the reset line, kicks the watchdog while running
// assumes the bench changes kick_en off the rising edge
`timescale 1ns/1ps
module rsw_cpu_model #(
    parameter int GAP = 30
) (
    input  wire logic clk_sys,
    input  wire logic reset_out_n_o,
    input  wire logic reset_out_n_oe,
    input  wire logic kick_en,
    output logic      kick_input_n
);
    // open-drain line floats high through its pull-up when released
    wire reset_line_n = reset_out_n_oe ? reset_out_n_o : 1'b1;
    // the line is held low during rst_b, so the first falling edge drives kick high
    int  cnt = 0;
    // one-cycle low pulse every GAP+1 cycles, well inside the shortest period
    always @(negedge clk_sys) begin
        cnt = (reset_line_n && kick_en && cnt < GAP) ? cnt + 1 : 0;
        kick_input_n <= (cnt != GAP);
    end
endmodule : rsw_cpu_model

// [dv/reset_supervisor_watchdog_tb_top.sv]
// testbench for the reset supervisor: power-up, fail, button, watchdog
// assumes shortened counts; the cpu model kicks unless kick_en is low
`timescale 1ns/1ps
module reset_supervisor_watchdog_tb_top;
    localparam int STR = 50;
    localparam int LIM [4] = '{100, 200, 300, 200};
    logic       clk_sys = 1'b0;
    logic       rst_b = 1'b0;
    logic       power_fail = 1'b0;
    logic       pushbutton_reset_n = 1'b1;
    logic [1:0] watchdog_period_select = 2'h0;
    logic       kick_en = 1'b1;
    logic       kick_input_n, reset_out, reset_out_n_o, reset_out_n_oe;
    int         errors = 0;
    int         comparisons = 0;
    int         n;
    always #12.5 clk_sys = ~clk_sys;
    rsw_supervisor #(.STRETCH_CYCLES(STR), .DEBOUNCE_CYCLES(4), .WD_SHORT_CYCLES(100),
        .WD_MID_CYCLES(200), .WD_LONG_CYCLES(300)) dut (
        .clk_sys                (clk_sys),
        .rst_b                  (rst_b),
        .power_fail             (power_fail),
        .pushbutton_reset_n     (pushbutton_reset_n),
        .kick_input_n           (kick_input_n),
        .watchdog_period_select (watchdog_period_select),
        .reset_out              (reset_out),
        .reset_out_n_o          (reset_out_n_o),
        .reset_out_n_oe         (reset_out_n_oe)
    );
    rsw_cpu_model u_cpu (.clk_sys(clk_sys), .reset_out_n_o(reset_out_n_o),
        .reset_out_n_oe(reset_out_n_oe), .kick_en(kick_en), .kick_input_n(kick_input_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
            $display("MISMATCH %0t seen %0h expected %0h errors %0d", $time, seen, exp, ++errors);
    endtask : check
    // counts falling edges until reset_out reaches lvl, giving up after lmt
    task automatic wait_out(input logic lvl, input int lmt);
        for (n = 0; reset_out !== lvl && n < lmt; n++)
            @(negedge clk_sys);
    endtask : wait_out
    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic t_fail;
        power_fail = 1'b1;
        repeat (3) @(negedge clk_sys);
        check(32'({reset_out, reset_out_n_oe, reset_out_n_o}), 32'h6);
        pushbutton_reset_n = 1'b0;
        repeat (20) @(negedge clk_sys);
        power_fail = 1'b0;
        repeat (30) @(negedge clk_sys);
        pushbutton_reset_n = 1'b1;
        wait_out(1'b0, STR + 40);
        check(32'(n >= STR && n <= STR + 16), 32'h1);
    endtask : t_fail
    task automatic t_button;
        pushbutton_reset_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        pushbutton_reset_n = 1'b1;
        repeat (12) @(negedge clk_sys);
        check(32'(reset_out), 32'h0);
        pushbutton_reset_n = 1'b0;
        repeat (12) @(negedge clk_sys);
        check(32'(reset_out), 32'h1);
        pushbutton_reset_n = 1'b1;
        wait_out(1'b0, STR + 40);
        check(32'(n >= STR && n <= STR + 16), 32'h1);
    endtask : t_button
    task automatic t_wd(input int s);
        watchdog_period_select = 2'(s);
        wait_out(1'b1, 400);
        check(n, 400);
        kick_en = 1'b0;
        wait_out(1'b1, 360);
        wait_out(1'b0, STR + 40);
        check(32'(n >= STR), 32'h1);
        wait_out(1'b1, 400);
        check(32'(n >= LIM[s] - 2 && n <= LIM[s] + 8), 32'h1);
        kick_en = 1'b1;
        wait_out(1'b0, STR + 40);
    endtask : t_wd
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_b = 1'b1;
        wait_out(1'b0, STR + 40);
        check(32'(n >= STR && n <= STR + 16), 32'h1);
        t_fail();
        t_button();
        for (int s = 0; s < 4; s++)
            t_wd(s);
        complete_run();
    end
    initial begin
        #(25 * 20000);
        errors++;
        complete_run();
    end
endmodule : reset_supervisor_watchdog_tb_top
